// ---- parcel_instruction_decoder_tb.sv ----
// Self-checking bench for the parcel instruction decoder with a fetch buffer model.
// Assumes the decoder issues in program order and flushes on a redirect pulse.
`timescale 1ns/1ps
module parcel_instruction_decoder_tb;
	typedef struct {
		logic [15:0] p0, p1, p2;
		logic [1:0] len;
		pid_pkg::pid_fmt_e fmt;
		logic [31:0] imm;
		logic ci, err, priv, co;
		logic [63:0] opk;
	} pid_row_s;

	logic clk_sys, rst_b, mode_wide, mon_mode, fetch_valid, fetch_ready, br_valid, issue_valid, issue_ready, slow;
	logic [63:0] fetch_word;
	logic [23:0] br_target;
	pid_pkg::pid_rsel_s rd_sel;
	pid_pkg::pid_trio_t rd_data, issue_opnd;
	pid_pkg::pid_dec_s issue;
	pid_row_s rows [15];
	int failures, total_checks;

	pid_decoder dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .mode_wide(mode_wide), .mon_mode(mon_mode),
		.fetch_word(fetch_word), .fetch_valid(fetch_valid), .fetch_ready(fetch_ready), .br_valid(br_valid),
		.br_target(br_target), .rd_sel(rd_sel), .rd_data(rd_data), .issue_valid(issue_valid),
		.issue_ready(issue_ready), .issue(issue), .issue_opnd(issue_opnd));
	pid_fetch_model model_u (.clk_sys(clk_sys), .rst_b(rst_b), .slow(slow), .fetch_ready(fetch_ready),
		.br_valid(br_valid), .br_target(br_target), .rd_sel(rd_sel), .fetch_word(fetch_word),
		.fetch_valid(fetch_valid), .rd_data(rd_data));

	// Free-running 200 MHz clock.
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Counts a comparison and reports a mismatch at once.
	task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Packs row parcels back to back from a parcel address, most significant parcel first.
	task automatic load(input int first, input int last, input int pa);
		for (int r = first; r <= last; r++) begin
			model_u.mem[pa / 4][(3 - pa % 4) * 16 +: 16] = rows[r].p0;
			if (rows[r].len > 2'h1) model_u.mem[(pa + 1) / 4][(3 - (pa + 1) % 4) * 16 +: 16] = rows[r].p1;
			if (rows[r].len > 2'h2) model_u.mem[(pa + 2) / 4][(3 - (pa + 2) % 4) * 16 +: 16] = rows[r].p2;
			pa += rows[r].len;
		end
	endtask

	// One-cycle redirect; fetch is refused meanwhile and the issue register empties.
	task automatic redirect(input logic [23:0] tgt);
		@(negedge clk_sys);
		br_valid <= 1'b1;
		br_target <= tgt;
		#1 check("fetch_ready_in_redirect", fetch_ready, 1'b0);
		@(negedge clk_sys);
		br_valid <= 1'b0;
		check("issue_valid_after_redirect", issue_valid, 1'b0);
	endtask

	// Takes issued instructions and compares them with the rows, stalling on even cycles when slow.
	task automatic run(input int first, input int last, input logic [23:0] pc0);
		int r;
		int n;
		logic rdy;
		logic [23:0] pc;
		logic [63:0] eh;
		r = first;
		n = 0;
		pc = pc0;
		while (r <= last && n < 200) begin
			@(negedge clk_sys);
			n++;
			rdy = !slow || n[0];
			issue_ready <= rdy;
			if (issue_valid === 1'b1 && rdy) begin
				check("pc", issue.pc, pc);
				check("len", issue.len, rows[r].len);
				check("fmt", issue.fmt, rows[r].fmt);
				check("opcode", issue.opc7, rows[r].p0[15:9]);
				check("dest", issue.i, rows[r].p0[8:6]);
				if (rows[r].ci) check("imm", issue.imm, rows[r].imm);
				if (rows[r].p0[15]) check("index", issue.h, rows[r].p0[11:9]);
				if (rows[r].fmt == pid_pkg::F1_COMB) check("jk", issue.jk, rows[r].p0[5:0]);
				check("err", issue.err, rows[r].err);
				check("nop", issue.nop, rows[r].err | (rows[r].priv & !mon_mode));
				if (rows[r].co) check("opnd_j", issue_opnd[pid_pkg::D_J], pid_pkg::ZERO64);
				if (rows[r].co) check("opnd_k", issue_opnd[pid_pkg::D_K], rows[r].opk);
				eh = (rows[r].p0[11:9] == 3'h0) ? 64'h0 : (64'hc3c3c3c35a5a5a50 | 64'(rows[r].p0[11:9]));
				check("opnd_h", issue_opnd[pid_pkg::D_H], eh & (mode_wide ? pid_pkg::A_WIDE : pid_pkg::A_NARROW));
				check("wide", issue.wide, mode_wide);
				if (rows[r].fmt == pid_pkg::F1_DISC) begin
					check("k", issue.k, (rows[r].p0[15:9] == pid_pkg::OP_POP) ? 3'h0 : rows[r].p0[2:0]);
				end
				pc = pc + 24'(rows[r].len);
				r++;
			end
		end
		if (r <= last) begin
			failures++;
			$display("[FAIL] issue wait expected %0d seen %0d", last + 1, r);
			test_done();
		end
	endtask

	// Main sequence: reset, wide rows prompt and stalled, then the narrow-mode cases.
	initial begin
		rst_b = 1'b0;
		mode_wide = 1'b1;
		mon_mode = 1'b0;
		br_valid = 1'b0;
		br_target = 24'h0;
		issue_ready = 1'b0;
		slow = 1'b0;
		failures = 0;
		total_checks = 0;
		rows = '{
			'{16'h3040, 16'h0, 16'h0, 2'h1, pid_pkg::F1_DISC, 32'h0, 1'b0, 1'b0, 1'b0, 1'b1, pid_pkg::K0_A},
			'{16'h6080, 16'h0, 16'h0, 2'h1, pid_pkg::F1_DISC, 32'h0, 1'b0, 1'b0, 1'b0, 1'b1, pid_pkg::K0_S},
			'{16'h448f, 16'h0, 16'h0, 2'h1, pid_pkg::F1_COMB, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0, 64'h0},
			'{16'h20ca, 16'h1234, 16'h0, 2'h2, pid_pkg::F2_JKM, 32'h000a1234, 1'b1, 1'b0, 1'b0, 1'b0, 64'h0},
			'{16'h8505, 16'h00ff, 16'h0, 2'h2, pid_pkg::F2_JKM, 32'h000500ff, 1'b1, 1'b0, 1'b0, 1'b0, 64'h0},
			'{16'h0c53, 16'habcd, 16'h0, 2'h2, pid_pkg::F2_IJKM, 32'h0053abcd, 1'b1, 1'b0, 1'b0, 1'b0, 64'h0},
			'{16'h1b01, 16'h0001, 16'h0, 2'h2, pid_pkg::F2_IJKM, 32'h00010001, 1'b1, 1'b0, 1'b0, 1'b0, 64'h0},
			'{16'h4040, 16'h5678, 16'h9abc, 2'h3, pid_pkg::F3_MN, 32'h9abc5678, 1'b1, 1'b0, 1'b0, 1'b0, 64'h0},
			'{16'hb280, 16'h0000, 16'hffff, 2'h3, pid_pkg::F3_MN, 32'hffff0000, 1'b1, 1'b0, 1'b0, 1'b0, 64'h0},
			'{16'h0200, 16'h0, 16'h0, 2'h1, pid_pkg::F1_DISC, 32'h0, 1'b0, 1'b0, 1'b1, 1'b0, 64'h0},
			'{16'h4040, 16'h1111, 16'h2222, 2'h3, pid_pkg::F3_MN, 32'h0, 1'b0, 1'b1, 1'b0, 1'b0, 64'h0},
			'{16'h207f, 16'hffff, 16'h0, 2'h2, pid_pkg::F2_JKM, 32'h003fffff, 1'b1, 1'b0, 1'b0, 1'b0, 64'h0},
			'{16'h3240, 16'h0, 16'h0, 2'h1, pid_pkg::F1_DISC, 32'h0, 1'b0, 1'b0, 1'b0, 1'b1, pid_pkg::K0_A},
			'{16'h2c53, 16'h0, 16'h0, 2'h1, pid_pkg::F1_DISC, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0, 64'h0},
			'{16'h1053, 16'habcd, 16'h0, 2'h2, pid_pkg::F2_IJKM, 32'h0053abcd, 1'b1, 1'b0, 1'b0, 1'b0, 64'h0}};
		repeat (3) @(negedge clk_sys);
		load(0, 9, 0);
		load(10, 14, 33);
		check("issue_valid_in_reset", issue_valid, 1'b0);
		check("fetch_ready_in_reset", fetch_ready, 1'b1);
		repeat (3) @(negedge clk_sys);
		rst_b <= 1'b1;
		run(0, 9, 24'h0);
		slow <= 1'b1;
		mon_mode <= 1'b1;
		redirect(24'h0);
		run(0, 9, 24'h0);
		slow <= 1'b0;
		mode_wide <= 1'b0;
		redirect(24'd33);
		run(10, 14, 24'd33);
		// A reset in mid-run empties the issue register at once.
		rst_b <= 1'b0;
		@(negedge clk_sys);
		check("issue_valid_mid_reset", issue_valid, 1'b0);
		check("pc_mid_reset", issue.pc, 24'h0);
		rst_b <= 1'b1;
		test_done();
	end
endmodule

// ---- pid_decoder.sv ----
// Parcel instruction decoder: two-word parcel window, length decode, field split and issue register.
// Assumes the fetch unit supplies words in program order and refetches after a redirect.
//
// Function
// - Instructions are one, two or three parcels; three only in wide mode.
// - A 64-bit word holds parcels 0 to 3, parcel 0 most significant.
// - Instructions start at any parcel and may span words; targets name any parcel.
// - Discrete format: g and h opcode, i destination, j and k sources.
// - Designators an operation does not use are disregarded.
// - Listed one-parcel instructions merge j and k into one 6-bit field.
// - Two-parcel constant: 7-bit opcode, i destination, 22-bit jkm value.
// - Two-parcel memory: 4-bit opcode, h index, i register, 22-bit jkm displacement.
// - Two-parcel branch: 7-bit opcode, 24-bit parcel address, i top bit zero.
// - Two-parcel 24-bit immediate: 4-bit opcode, h destination, i top bit one.
// - Three-parcel constant: 7-bit opcode, i destination, j and k zero.
// - Three-parcel value: second parcel low half, third parcel high half.
// - Three-parcel memory: 4-bit opcode, h index, i register, 32-bit field.
// - Wide mode enables three-parcel forms and full 32-bit address values.
// - Three-parcel instruction in narrow mode reports an error, no normal execution.
// - Program address range is 4 Mwords in both modes.
// - Narrow mode follows the context bit and drops the top 8 bits.
// - Zero source designators give constants 0, 1 for A-k, top bit for S-k.
// - Privileged instruction outside monitor mode issues as a no-operation.
`timescale 1ns/1ps
module pid_decoder (
	input wire logic clk_sys, // System clock, 200 MHz.
	input wire logic rst_b, // Asynchronous reset, active low.
	input wire logic mode_wide, // Extended addressing bit, high for wide mode.
	input wire logic mon_mode, // High while the processor is in monitor mode.
	input wire logic [63:0] fetch_word, // Instruction word from the fetch buffer.
	input wire logic fetch_valid, // Fetch word is valid.
	output logic fetch_ready, // Decoder can take a fetch word.
	input wire logic br_valid, // Redirect to a new parcel address, one cycle.
	input wire logic [23:0] br_target, // Redirect parcel address.
	output pid_pkg::pid_rsel_s rd_sel, // Register designators for operand reads.
	input wire pid_pkg::pid_trio_t rd_data, // Register contents for rd_sel.
	output logic issue_valid, // Decoded instruction is valid.
	input wire logic issue_ready, // Downstream takes the instruction.
	output pid_pkg::pid_dec_s issue, // Decoded instruction fields.
	output pid_pkg::pid_trio_t issue_opnd // Operands with special values applied.
);

	logic [63:0] cur_word_r, cur_word_nxt;
	logic [63:0] nxt_word_r, nxt_word_nxt;
	logic cur_vld_r, cur_vld_nxt;
	logic nxt_vld_r, nxt_vld_nxt;
	logic [1:0] ptr_r, ptr_nxt;
	logic [21:0] pc_word_r, pc_word_nxt;
	pid_pkg::pid_dec_s out_r, out_nxt;
	pid_pkg::pid_trio_t opnd_r, opnd_nxt;
	logic out_vld_r, out_vld_nxt;

	logic [127:0] win;
	logic [15:0] p0, p1, p2;
	logic [6:0] gh;
	logic [3:0] g;
	logic [2:0] fh, fi, fj, fk;
	logic is_const, is_mem, is_comb, is_br24, is_jmp, is_p3, is_two;
	logic [1:0] len;
	logic [2:0] end_pos;
	logic avail, ld, s_cls;
	logic [2:0] use_m;
	pid_pkg::pid_dec_s dec;
	pid_pkg::pid_trio_t opnd_c;

	// The window holds the current and the next word, shifted so parcel 0 is the pointed one.
	always_comb begin
		win = {cur_word_r, nxt_word_r} << {ptr_r, 4'h0};
		p0 = win[127:112];
		p1 = win[111:96];
		p2 = win[95:80];
		gh = p0[15:9];
		g = p0[15:12];
		fh = p0[11:9];
		fi = p0[8:6];
		fj = p0[5:3];
		fk = p0[2:0];
	end

	// Opcode classes pick the length; j and k both zero marks the three-parcel variant.
	always_comb begin
		is_const = (gh == pid_pkg::OP_CA) || (gh == pid_pkg::OP_CA_N) ||
			(gh == pid_pkg::OP_CS) || (gh == pid_pkg::OP_CS_N);
		is_mem = (g >= pid_pkg::G_MEM_LO) && (g <= pid_pkg::G_MEM_HI);
		is_br24 = (g == pid_pkg::G_BR24);
		is_jmp = (gh == pid_pkg::OP_JMP_LO) || (gh == pid_pkg::OP_JMP_HI);
		is_comb = 1'b0;
		for (int n = 0; n < pid_pkg::N_COMB; n++) begin
			if (gh == pid_pkg::COMB_OPS[n]) begin
				is_comb = 1'b1;
			end
		end
		is_p3 = (is_const || is_mem) && (fj == 3'h0) && (fk == 3'h0);
		is_two = is_const || is_mem || is_br24 || is_jmp;
		if (is_p3) begin
			len = pid_pkg::LEN3;
		end else if (is_two) begin
			len = pid_pkg::LEN2;
		end else begin
			len = pid_pkg::LEN1;
		end
		end_pos = {1'b0, ptr_r} + {1'b0, len};
	end

	// Issue is held until every parcel is present, including those in the next word.
	always_comb begin
		avail = cur_vld_r && ((end_pos <= pid_pkg::WORD_END) || nxt_vld_r);
		ld = avail && (!out_vld_r || issue_ready) && !br_valid;
	end

	// Operations that leave a designator unused get a mask that clears it.
	always_comb begin
		use_m = pid_pkg::USE_ALL;
		if ((gh == pid_pkg::OP_POP) || (gh == pid_pkg::OP_LZ)) begin
			use_m = pid_pkg::USE_IJ;
		end else if (gh == pid_pkg::OP_FCONST) begin
			use_m = pid_pkg::USE_IK;
		end
		s_cls = (gh >= pid_pkg::OP_S_LO) && (gh <= pid_pkg::OP_S_HI);
	end

	// Field split for the five format variants.
	always_comb begin
		dec = '0;
		dec.pc = {pc_word_r, ptr_r};
		dec.len = len;
		dec.opc7 = gh;
		dec.opc4 = g;
		dec.h = fh;
		dec.i = fi;
		dec.j = fj;
		dec.k = fk;
		dec.use_ijk = pid_pkg::USE_ALL;
		dec.jk = p0[5:0];
		dec.wide = mode_wide;
		dec.is_mem = is_mem;
		if (is_p3) begin
			dec.fmt = pid_pkg::F3_MN;
			dec.imm = {p2, p1};
		end else if (is_const || is_mem) begin
			dec.fmt = pid_pkg::F2_JKM;
			dec.imm = 32'({p0[5:0], p1});
		end else if (is_jmp || (is_br24 && !fi[2])) begin
			dec.fmt = pid_pkg::F2_IJKM;
			dec.imm = 32'({p0[7:0], p1});
			dec.is_branch = 1'b1;
		end else if (is_br24) begin
			dec.fmt = pid_pkg::F2_IJKM;
			dec.imm = 32'({p0[7:0], p1});
		end else if (is_comb) begin
			dec.fmt = pid_pkg::F1_COMB;
			dec.imm = 32'(p0[5:0]);
			dec.is_branch = (gh == pid_pkg::OP_BR1);
		end else begin
			dec.fmt = pid_pkg::F1_DISC;
			dec.use_ijk = use_m;
			dec.i = use_m[2] ? fi : 3'h0;
			dec.j = use_m[1] ? fj : 3'h0;
			dec.k = use_m[0] ? fk : 3'h0;
		end
		if (!mode_wide) begin
			dec.imm = dec.imm & pid_pkg::NARROW_MASK;
		end
		dec.err = is_p3 && !mode_wide;
		dec.nop = dec.err || ((gh == pid_pkg::OP_PRIV) && !mon_mode);
	end

	// Register reads are addressed straight from the pointed instruction.
	always_comb begin
		rd_sel.h = fh;
		rd_sel.j = fj;
		rd_sel.k = fk;
	end

	// One selector per source designator applies the zero-designator constants.
	for (genvar d = 0; d < 3; d++) begin : g_opnd
		pid_operand_sel #(
			.KIND(d)
		) u_sel (
			.fld(d == pid_pkg::D_H ? fh : (d == pid_pkg::D_J ? fj : fk)),
			.s_cls(d == pid_pkg::D_H ? 1'b0 : s_cls),
			.wide(mode_wide),
			.rd_data(rd_data[d]),
			.value(opnd_c[d])
		);
	end

	// Parcel window next state: consume, shift words at a boundary, accept fetch, redirect.
	always_comb begin
		cur_word_nxt = cur_word_r;
		nxt_word_nxt = nxt_word_r;
		cur_vld_nxt = cur_vld_r;
		nxt_vld_nxt = nxt_vld_r;
		ptr_nxt = ptr_r;
		pc_word_nxt = pc_word_r;
		if (br_valid) begin
			cur_vld_nxt = 1'b0;
			nxt_vld_nxt = 1'b0;
			ptr_nxt = br_target[1:0];
			pc_word_nxt = br_target[23:2];
		end else begin
			if (ld) begin
				ptr_nxt = end_pos[1:0];
				if (end_pos >= pid_pkg::WORD_END) begin
					cur_word_nxt = nxt_word_r;
					cur_vld_nxt = nxt_vld_r;
					nxt_vld_nxt = 1'b0;
					pc_word_nxt = pc_word_r + 22'h1;
				end
			end
			if (fetch_valid && fetch_ready) begin
				if (!cur_vld_nxt) begin
					cur_word_nxt = fetch_word;
					cur_vld_nxt = 1'b1;
				end else begin
					nxt_word_nxt = fetch_word;
					nxt_vld_nxt = 1'b1;
				end
			end
		end
	end

	// A free second slot is enough to take a word; a redirect refuses the cycle.
	always_comb begin
		fetch_ready = !nxt_vld_r && !br_valid;
	end

	// Parcel window registers.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cur_word_r <= 64'h0;
			nxt_word_r <= 64'h0;
			cur_vld_r <= 1'b0;
			nxt_vld_r <= 1'b0;
			ptr_r <= 2'h0;
			pc_word_r <= 22'h0;
		end else begin
			cur_word_r <= cur_word_nxt;
			nxt_word_r <= nxt_word_nxt;
			cur_vld_r <= cur_vld_nxt;
			nxt_vld_r <= nxt_vld_nxt;
			ptr_r <= ptr_nxt;
			pc_word_r <= pc_word_nxt;
		end
	end

	// Issue register next state: load on decode, drop on take, flush on redirect.
	always_comb begin
		out_nxt = out_r;
		opnd_nxt = opnd_r;
		out_vld_nxt = out_vld_r;
		if (br_valid) begin
			out_vld_nxt = 1'b0;
		end else if (ld) begin
			out_nxt = dec;
			opnd_nxt = opnd_c;
			out_vld_nxt = 1'b1;
		end else if (issue_ready) begin
			out_vld_nxt = 1'b0;
		end
	end

	// Issue registers.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			out_r <= '0;
			opnd_r <= '0;
			out_vld_r <= 1'b0;
		end else begin
			out_r <= out_nxt;
			opnd_r <= opnd_nxt;
			out_vld_r <= out_vld_nxt;
		end
	end

	// Issue outputs come from the registers.
	always_comb begin
		issue_valid = out_vld_r;
		issue = out_r;
		issue_opnd = opnd_r;
	end

	// Checks on the decoder's own behaviour.
	sequence s_ld_span;
		ld && (end_pos > pid_pkg::WORD_END);
	endsequence

	sequence s_ld_long;
		ld && (len == pid_pkg::LEN3);
	endsequence

	property p_len_legal;
		@(posedge clk_sys) disable iff (!rst_b)
		issue_valid && (issue.len == pid_pkg::LEN3) |-> issue.wide || (issue.err && issue.nop);
	endproperty
	a_len_legal: assert property (p_len_legal) else $error("Three-parcel issue in narrow mode without error.");

	property p_narrow_err;
		@(posedge clk_sys) disable iff (!rst_b)
		s_ld_long ##0 !mode_wide |=> issue_valid && issue.err && issue.nop;
	endproperty
	a_narrow_err: assert property (p_narrow_err) else $error("Narrow-mode long instruction not flagged.");

	property p_mn_order;
		@(posedge clk_sys) disable iff (!rst_b)
		s_ld_long ##0 mode_wide |=> issue.imm == {$past(p2), $past(p1)} && issue.fmt == pid_pkg::F3_MN;
	endproperty
	a_mn_order: assert property (p_mn_order) else $error("Three-parcel constant halves misplaced.");

	property p_span_wait;
		@(posedge clk_sys) disable iff (!rst_b)
		s_ld_span |-> nxt_vld_r ##1 (ptr_r == $past(end_pos[1:0])) && (pc_word_r == $past(pc_word_r) + 22'h1);
	endproperty
	a_span_wait: assert property (p_span_wait) else $error("Spanning instruction issued early or pointer wrong.");

	property p_pc_tag;
		@(posedge clk_sys) disable iff (!rst_b)
		ld |=> issue.pc == {$past(pc_word_r), $past(ptr_r)} && issue.len == $past(len);
	endproperty
	a_pc_tag: assert property (p_pc_tag) else $error("Issued parcel address does not match pointer.");

	property p_priv_nop;
		@(posedge clk_sys) disable iff (!rst_b)
		ld && (gh == pid_pkg::OP_PRIV) && !mon_mode |=> issue.nop;
	endproperty
	a_priv_nop: assert property (p_priv_nop) else $error("Privileged instruction issued outside monitor mode.");

	property p_sk_zero;
		@(posedge clk_sys) disable iff (!rst_b)
		ld && s_cls && (fk == 3'h0) |=> issue_opnd[pid_pkg::D_K] == pid_pkg::K0_S;
	endproperty
	a_sk_zero: assert property (p_sk_zero) else $error("S register k zero did not give top bit.");

	property p_imm24;
		@(posedge clk_sys) disable iff (!rst_b)
		ld && is_br24 && fi[2] && mode_wide |=> issue.fmt == pid_pkg::F2_IJKM && !issue.is_branch
			&& issue.h == $past(fh) && issue.opc4 == pid_pkg::G_BR24;
	endproperty
	a_imm24: assert property (p_imm24) else $error("Immediate 24-bit form decoded wrongly.");

	property p_branch;
		@(posedge clk_sys) disable iff (!rst_b)
		ld && is_br24 && !fi[2] |=> issue.is_branch && issue.imm[23:16] == $past(p0[7:0]);
	endproperty
	a_branch: assert property (p_branch) else $error("Branch target field decoded wrongly.");

	property p_narrow_mask;
		@(posedge clk_sys) disable iff (!rst_b)
		ld && !mode_wide |=> issue.imm[31:24] == 8'h00 && !issue.wide;
	endproperty
	a_narrow_mask: assert property (p_narrow_mask) else $error("Narrow mode kept upper value bits.");

endmodule

// ---- pid_fetch_model.sv ----
// Fetch buffer and register file model facing the parcel instruction decoder.
// Assumes the bench loads mem before reset is released and before each redirect.
`timescale 1ns/1ps
module pid_fetch_model (
	input wire logic clk_sys, // System clock.
	input wire logic rst_b, // Reset, active low.
	input wire logic slow, // High to leave one idle cycle after each taken word.
	input wire logic fetch_ready, // Decoder takes the offered word.
	input wire logic br_valid, // Redirect pulse.
	input wire logic [23:0] br_target, // Redirect parcel address.
	input wire pid_pkg::pid_rsel_s rd_sel, // Designators to read.
	output logic [63:0] fetch_word, // Offered word.
	output logic fetch_valid, // Offered word is valid.
	output pid_pkg::pid_trio_t rd_data // Register contents for rd_sel.
);
	logic [63:0] mem [16];
	logic [21:0] wa_r;
	logic gap_r;

	// Memory starts cleared; the bench fills it before use.
	initial begin
		for (int w = 0; w < 16; w++) begin
			mem[w] = 64'h0;
		end
	end

	// Word pointer follows takes and jumps to the word holding a redirect target.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wa_r <= 22'h0;
			gap_r <= 1'b0;
		end else if (br_valid) begin
			wa_r <= br_target[23:2];
			gap_r <= 1'b0;
		end else if (fetch_valid && fetch_ready) begin
			wa_r <= wa_r + 22'h1;
			gap_r <= slow;
		end else begin
			gap_r <= 1'b0;
		end
	end

	// Offer after the edge and hold until taken; an idle bus shows a scrambled word.
	always @(negedge clk_sys) begin
		if (!rst_b) begin
			fetch_valid <= 1'b0;
			fetch_word <= 64'h0;
		end else if (gap_r) begin
			fetch_valid <= 1'b0;
			fetch_word <= ~fetch_word;
		end else begin
			fetch_valid <= 1'b1;
			fetch_word <= mem[wa_r[3:0]];
		end
	end

	// Register contents are never zero, so a zero-designator constant stands out.
	assign rd_data[pid_pkg::D_H] = 64'hc3c3c3c35a5a5a50 | {61'h0, rd_sel.h};
	assign rd_data[pid_pkg::D_J] = 64'hc3c3c3c35a5a5a50 | {61'h0, rd_sel.j};
	assign rd_data[pid_pkg::D_K] = 64'hc3c3c3c35a5a5a50 | {61'h0, rd_sel.k};
endmodule

// ---- pid_operand_sel.sv ----
// Operand selector for one source designator of the parcel instruction decoder.
// Assumes the register contents arrive in the same cycle as the designator.
`timescale 1ns/1ps
module pid_operand_sel #(
	parameter int KIND = pid_pkg::D_J
) (
	input wire logic [2:0] fld, // Designator field value.
	input wire logic s_cls, // High when the designator names an S register.
	input wire logic wide, // High in wide addressing mode.
	input wire logic [63:0] rd_data, // Register contents for the designator.
	output logic [63:0] value // Operand as the functional unit sees it.
);

	logic [63:0] raw;

	// A zero designator gives a constant, and A values lose bits above the address width.
	always_comb begin
		raw = rd_data;
		if (fld == 3'h0) begin
			if (KIND == pid_pkg::D_K) begin
				raw = s_cls ? pid_pkg::K0_S : pid_pkg::K0_A;
			end else begin
				raw = pid_pkg::ZERO64;
			end
		end
		if (s_cls) begin
			value = raw;
		end else begin
			value = raw & (wide ? pid_pkg::A_WIDE : pid_pkg::A_NARROW);
		end
	end

endmodule

// ---- pid_pkg.sv ----
// Package for the parcel instruction decoder: widths, opcode groups, formats and carriers.
// Assumes 16-bit parcels packed four to a 64-bit word, most significant parcel first.
package pid_pkg;

	// Widths of parcels, words, fields and addresses.
	localparam int PARCEL_W = 16;
	localparam int WORD_W = 64;
	localparam int PARCELS = 4;
	localparam int PADDR_W = 24;
	localparam int WADDR_W = 22;
	localparam int PTR_W = 2;

	// Instruction lengths in parcels.
	localparam logic [1:0] LEN1 = 2'h1;
	localparam logic [1:0] LEN2 = 2'h2;
	localparam logic [1:0] LEN3 = 2'h3;
	localparam logic [2:0] WORD_END = 3'h4;

	// Opcode groups on the seven-bit g/h code or the four-bit g code.
	localparam logic [6:0] OP_PRIV = 7'h01;
	localparam logic [6:0] OP_BR1 = 7'h05;
	localparam logic [6:0] OP_JMP_LO = 7'h06;
	localparam logic [6:0] OP_JMP_HI = 7'h07;
	localparam logic [6:0] OP_CA = 7'h10;
	localparam logic [6:0] OP_CA_N = 7'h11;
	localparam logic [6:0] OP_CS = 7'h20;
	localparam logic [6:0] OP_CS_N = 7'h21;
	localparam logic [6:0] OP_POP = 7'h16;
	localparam logic [6:0] OP_LZ = 7'h17;
	localparam logic [6:0] OP_FCONST = 7'h39;
	localparam logic [6:0] OP_S_LO = 7'h20;
	localparam logic [6:0] OP_S_HI = 7'h3f;
	localparam logic [3:0] G_BR24 = 4'h1;
	localparam logic [3:0] G_MEM_LO = 4'h8;
	localparam logic [3:0] G_MEM_HI = 4'hb;
	localparam int N_COMB = 16;
	localparam logic [6:0] COMB_OPS [N_COMB] = '{7'h05, 7'h12, 7'h14, 7'h15, 7'h1c, 7'h1d, 7'h1e, 7'h1f,
		7'h22, 7'h23, 7'h2a, 7'h2b, 7'h2c, 7'h2d, 7'h3d, 7'h3e};

	// Designator use masks, bit 2 is i, bit 1 is j, bit 0 is k.
	localparam logic [2:0] USE_ALL = 3'h7;
	localparam logic [2:0] USE_IJ = 3'h6;
	localparam logic [2:0] USE_IK = 3'h5;

	// Special operands for a zero designator and the narrow-mode value mask.
	localparam logic [63:0] K0_A = 64'h0000000000000001;
	localparam logic [63:0] K0_S = 64'h8000000000000000;
	localparam logic [63:0] ZERO64 = 64'h0000000000000000;
	localparam logic [31:0] NARROW_MASK = 32'h00ffffff;
	localparam logic [63:0] A_NARROW = 64'h0000000000ffffff;
	localparam logic [63:0] A_WIDE = 64'h00000000ffffffff;

	// Designator positions in the operand trio.
	localparam int D_K = 0;
	localparam int D_J = 1;
	localparam int D_H = 2;

	// Instruction format variants.
	typedef enum logic [4:0] {
		F1_DISC = 5'h01,
		F1_COMB = 5'h02,
		F2_JKM = 5'h04,
		F2_IJKM = 5'h08,
		F3_MN = 5'h10
	} pid_fmt_e;

	// One decoded instruction as handed to the issue stage.
	typedef struct packed {
		logic [PADDR_W-1:0] pc;
		logic [1:0] len;
		pid_fmt_e fmt;
		logic [6:0] opc7;
		logic [3:0] opc4;
		logic [2:0] h;
		logic [2:0] i;
		logic [2:0] j;
		logic [2:0] k;
		logic [2:0] use_ijk;
		logic [5:0] jk;
		logic [31:0] imm;
		logic is_branch;
		logic is_mem;
		logic wide;
		logic nop;
		logic err;
	} pid_dec_s;

	// Register designators sent to the register files for operand reads.
	typedef struct packed {
		logic [2:0] h;
		logic [2:0] j;
		logic [2:0] k;
	} pid_rsel_s;

	// Operand values indexed by D_H, D_J and D_K.
	typedef logic [2:0][63:0] pid_trio_t;

endpackage
